// >>> design/dcksl_cmd_decode.v
// Command decoder from sampled control pins
`timescale 1ns/100ps
`default_nettype none
`include "dcksl_map.vh"
module dcksl_cmd_decode (
	input wire cs_n_in,
	input wire ras_n_in,
	input wire cas_n_in,
	input wire we_n_in,
	output reg [2:0] cmd_out
);
	always @* begin
		if (cs_n_in) begin
			cmd_out = `DCKSL_CMD_DSL;
		end else begin
			case ({ras_n_in, cas_n_in, we_n_in})
			3'h7: cmd_out = `DCKSL_CMD_NOP;
			3'h3: cmd_out = `DCKSL_CMD_ACT;
			3'h2: cmd_out = `DCKSL_CMD_PRE;
			3'h5: cmd_out = `DCKSL_CMD_RD;
			3'h4: cmd_out = `DCKSL_CMD_WR;
			3'h1: cmd_out = `DCKSL_CMD_REF;
			default: cmd_out = `DCKSL_CMD_MRS;
			endcase
		end
	end
endmodule // dcksl_cmd_decode
`default_nettype wire

// >>> design/dcksl_map.vh
// Constants for the command and clock-enable state logic
`ifndef DCKSL_MAP_VH
`define DCKSL_MAP_VH
// Decoded commands
`define DCKSL_CMD_DSL 3'h0
`define DCKSL_CMD_NOP 3'h1
`define DCKSL_CMD_ACT 3'h2
`define DCKSL_CMD_PRE 3'h3
`define DCKSL_CMD_RD 3'h4
`define DCKSL_CMD_WR 3'h5
`define DCKSL_CMD_REF 3'h6
`define DCKSL_CMD_MRS 3'h7
// Device states
`define DCKSL_ST_IDLE 3'h0
`define DCKSL_ST_ACTIVE 3'h1
`define DCKSL_ST_READ 3'h2
`define DCKSL_ST_WRITE 3'h3
`define DCKSL_ST_PPD 3'h4
`define DCKSL_ST_APD 3'h5
`define DCKSL_ST_SREF 3'h6
// Burst length in clocks (data beats / 2 at BL4)
`define DCKSL_BURST_CLKS 2'h2
`define DCKSL_BANKS 4
// Clocks from self refresh exit until a read is accepted
`define DCKSL_SREF_READ_CLKS 8'hc8
`endif

// >>> design/dcksl_state.v
// DDR2 command acceptance and clock-enable state logic
// What this block does
// - Commands decoded from pins at rising edge
// - CKE compared with previous edge sample
// - Action from this edge's command, prior state
// - CKE fall outside a burst enters power-down on NOP or deselect, or self refresh on REF with no rows open; rise exits
// - ODT ignored for states; off in self refresh
// - DM high blocks the write beat
// - Idle command handling, read/write illegal
// - Active bank command handling
// - Burst command handling and interrupts
`timescale 1ns/100ps
`default_nettype none
`include "dcksl_map.vh"
module dcksl_state (
	input wire core_clk_in,
	input wire rst_n_in,
	input wire cke_in,
	input wire cs_n_in,
	input wire ras_n_in,
	input wire cas_n_in,
	input wire we_n_in,
	input wire a10_in,
	input wire [1:0] ba_in,
	input wire odt_in,
	input wire dm_in,
	output reg [2:0] state_out,
	output reg illegal_out,
	output reg write_beat_out,
	output reg odt_active_out,
	output reg read_allowed_out,
	output reg [3:0] open_banks_out
);
	// Exit read wait after self refresh, in clocks
	localparam [7:0] SREF_READ_CLKS = `DCKSL_SREF_READ_CLKS;
	// Pin synchronisers, two stages each
	reg [6:0] sync1_reg;
	reg [6:0] sync2_reg;
	reg [1:0] ba1_reg;
	reg [1:0] ba2_reg;
	reg cke_prev_reg;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [3:0] open_reg;
	reg [3:0] open_next;
	reg [1:0] burst_reg;
	reg [1:0] burst_next;
	reg [7:0] xsrd_reg;
	reg [7:0] xsrd_next;
	reg bad_next;
	wire [2:0] cmd;
	wire cke_now;
	wire is_nop;

	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1_reg <= 7'h00;
			sync2_reg <= 7'h00;
			ba1_reg <= 2'h0;
			ba2_reg <= 2'h0;
		end else begin
			sync1_reg <= {dm_in, odt_in, a10_in, we_n_in, cas_n_in,
				ras_n_in, cs_n_in};
			sync2_reg <= sync1_reg;
			ba1_reg <= ba_in;
			ba2_reg <= ba1_reg;
		end
	end

	reg cke1_reg;
	reg cke2_reg;
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cke1_reg <= 1'b0;
			cke2_reg <= 1'b0;
		end else begin
			cke1_reg <= cke_in;
			cke2_reg <= cke1_reg;
		end
	end
	assign cke_now = cke2_reg;

	dcksl_cmd_decode u_dec (
		.cs_n_in(sync2_reg[0]),
		.ras_n_in(sync2_reg[1]),
		.cas_n_in(sync2_reg[2]),
		.we_n_in(sync2_reg[3]),
		.cmd_out(cmd)
	);
	assign is_nop = (cmd == `DCKSL_CMD_DSL) || (cmd == `DCKSL_CMD_NOP);

	// Bank mask of one bank, or all when A10 set on precharge
	function [3:0] bank_mask;
		input [1:0] ba;
		input all;
		begin
			bank_mask = all ? 4'hf : (4'h1 << ba);
		end
	endfunction

	// prior state plus this edge command
	always @* begin
		state_next = state_reg;
		open_next = open_reg;
		burst_next = (burst_reg != 2'h0) ? burst_reg - 2'h1 : 2'h0;
		xsrd_next = (xsrd_reg != 8'h00) ? xsrd_reg - 8'h01 : 8'h00;
		bad_next = 1'b0;
		case (state_reg)
		`DCKSL_ST_PPD, `DCKSL_ST_APD, `DCKSL_ST_SREF: begin
			if (cke_now) begin
				if (!is_nop) begin
					bad_next = 1'b1;
				end
				if (state_reg == `DCKSL_ST_SREF) begin
					xsrd_next = SREF_READ_CLKS;
				end
				state_next = (open_reg != 4'h0) ? `DCKSL_ST_ACTIVE :
					`DCKSL_ST_IDLE;
			end
		end
		default: begin
			if (cke_prev_reg && !cke_now) begin
				if (state_reg == `DCKSL_ST_READ ||
						state_reg == `DCKSL_ST_WRITE) begin
					bad_next = 1'b1;
				end else if (cmd == `DCKSL_CMD_REF) begin
					if (open_reg == 4'h0) begin
						state_next = `DCKSL_ST_SREF;
					end else begin
						bad_next = 1'b1;
					end
				end else if (is_nop) begin
					state_next = (open_reg != 4'h0) ? `DCKSL_ST_APD :
						`DCKSL_ST_PPD;
				end else begin
					bad_next = 1'b1;
				end
			end else if (!cke_now) begin
				bad_next = 1'b1;
			end else begin
				case (state_reg)
				`DCKSL_ST_IDLE: begin
					case (cmd)
					`DCKSL_CMD_ACT: begin
						open_next = bank_mask(ba2_reg, 1'b0);
						state_next = `DCKSL_ST_ACTIVE;
					end
					`DCKSL_CMD_RD, `DCKSL_CMD_WR: bad_next = 1'b1;
					default: state_next = `DCKSL_ST_IDLE;
					endcase
				end
				`DCKSL_ST_ACTIVE: begin
					case (cmd)
					`DCKSL_CMD_RD, `DCKSL_CMD_WR: begin
						if (xsrd_reg != 8'h00 && cmd == `DCKSL_CMD_RD) begin
							bad_next = 1'b1;
						end else begin
							burst_next = `DCKSL_BURST_CLKS;
							state_next = (cmd == `DCKSL_CMD_RD) ?
								`DCKSL_ST_READ : `DCKSL_ST_WRITE;
						end
					end
					`DCKSL_CMD_ACT: begin
						if ((open_reg & bank_mask(ba2_reg, 1'b0)) != 4'h0) begin
							bad_next = 1'b1;
						end else begin
							open_next = open_reg | bank_mask(ba2_reg, 1'b0);
						end
					end
					`DCKSL_CMD_PRE: begin
						open_next = open_reg & ~bank_mask(ba2_reg, sync2_reg[4]);
						if (open_next == 4'h0) begin
							state_next = `DCKSL_ST_IDLE;
						end
					end
					`DCKSL_CMD_REF, `DCKSL_CMD_MRS: bad_next = 1'b1;
					default: state_next = `DCKSL_ST_ACTIVE;
					endcase
				end
				default: begin
					if ((cmd == `DCKSL_CMD_RD && state_reg == `DCKSL_ST_READ) ||
						(cmd == `DCKSL_CMD_WR && state_reg == `DCKSL_ST_WRITE)) begin
						burst_next = `DCKSL_BURST_CLKS;
					end else if (!is_nop) begin
						bad_next = 1'b1;
					end else if (burst_reg <= 2'h1) begin
						state_next = `DCKSL_ST_ACTIVE;
					end
				end
				endcase
			end
		end
		endcase
	end

	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cke_prev_reg <= 1'b0;
			state_reg <= `DCKSL_ST_IDLE;
			open_reg <= 4'h0;
			burst_reg <= 2'h0;
			xsrd_reg <= 8'h00;
			state_out <= `DCKSL_ST_IDLE;
			illegal_out <= 1'b0;
			write_beat_out <= 1'b0;
			odt_active_out <= 1'b0;
			read_allowed_out <= 1'b1;
			open_banks_out <= 4'h0;
		end else begin
			cke_prev_reg <= cke_now;
			state_reg <= state_next;
			open_reg <= open_next;
			burst_reg <= burst_next;
			xsrd_reg <= xsrd_next;
			state_out <= state_next;
			illegal_out <= bad_next;
			write_beat_out <= (state_reg == `DCKSL_ST_WRITE) && !sync2_reg[6];
			odt_active_out <= sync2_reg[5] && (state_next != `DCKSL_ST_SREF);
			read_allowed_out <= (xsrd_next == 8'h00);
			open_banks_out <= open_next;
		end
	end
endmodule // dcksl_state
`default_nettype wire

// >>> sim/dcksl_ctl_model.sv
// Memory controller model driving the command pins
`timescale 1ns/100ps
`default_nettype none
`include "dcksl_map.vh"
module dcksl_ctl_model (
	input wire logic core_clk_in,
	output logic cke_out,
	output logic cs_n_out,
	output logic [2:0] rcw_n_out,
	output logic a10_out,
	output logic [1:0] ba_out
);
	// Row, column and write strobe levels for each command code
	localparam logic [23:0] enc_table = 24'h0654f8;
	initial begin
		cke_out = 1'b1;
		cs_n_out = 1'b1;
		rcw_n_out = 3'h7;
		a10_out = 1'b0;
		ba_out = 2'h0;
	end
	task automatic send(input logic [2:0] c, input logic k,
		input logic [1:0] b, input logic al);
		@(posedge core_clk_in);
		#1;
		cke_out = k;
		cs_n_out = c == `DCKSL_CMD_DSL;
		// Unselected lines toggle rather than keep their last level
		rcw_n_out = cs_n_out ? ~rcw_n_out : enc_table[c * 3 +: 3];
		a10_out = cs_n_out ? ~a10_out : al;
		ba_out = cs_n_out ? ~ba_out : b;
	endtask
endmodule // dcksl_ctl_model
`default_nettype wire

// >>> sim/dcksl_state_asserts.sv
// Checker for the command and clock-enable state logic
`timescale 1ns/100ps
`default_nettype none
module dcksl_state_chk (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic cke_in,
	input wire logic cs_n_in,
	input wire logic ras_n_in,
	input wire logic cas_n_in,
	input wire logic we_n_in,
	input wire logic [2:0] state_out,
	input wire logic illegal_out,
	input wire logic odt_active_out,
	input wire logic [3:0] open_banks_out
);
	wire rd = !cs_n_in && ras_n_in && !cas_n_in && we_n_in && cke_in;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	chk_illegal_hold: assert property (
		illegal_out |-> state_out == $past(state_out)) else $error("state moved");
	chk_burst_len: assert property (
		$changed(state_out) && state_out == 3'h2 |=> state_out == 3'h2)
		else $error("burst too short");
	chk_apd_open: assert property (
		$changed(state_out) && state_out == 3'h5 |-> open_banks_out != 4'h0)
		else $error("active pd no rows");
	chk_ppd_idle: assert property (
		$changed(state_out) && state_out == 3'h4
		|-> $past(state_out) == 3'h0 && open_banks_out == 4'h0)
		else $error("precharge pd not idle");
	chk_pd_cause: assert property (
		$changed(state_out) && state_out >= 3'h4
		|-> !$past(cke_in, 3) && $past(cke_in, 4)) else $error("entry no fall");
	chk_pd_exit: assert property (
		$changed(state_out) && $past(state_out) >= 3'h4 |-> $past(cke_in, 3))
		else $error("exit no rise");
	chk_odt_sref: assert property (
		state_out == 3'h6 && $past(state_out) == 3'h6 |-> !odt_active_out)
		else $error("odt in self refresh");
	chk_idle_read: assert property (
		$past(rd, 3) && $past(cke_in, 4) && state_out == 3'h0
		&& $past(state_out) == 3'h0 |-> illegal_out) else $error("read accepted");
endmodule // dcksl_state_chk
bind dcksl_state dcksl_state_chk dcksl_state_chk_inst (.core_clk_in, .rst_n_in,
	.cke_in, .cs_n_in, .ras_n_in, .cas_n_in, .we_n_in, .state_out, .illegal_out,
	.odt_active_out, .open_banks_out);
`default_nettype wire

// >>> sim/dcksl_state_test.sv
// Self-checking bench for the command and clock-enable state logic
`timescale 1ns/100ps
`default_nettype none
`include "dcksl_map.vh"
module dcksl_state_test;
	logic core_clk_in, rst_n_in, odt, dm;
	wire cke, cs_n, a10, ill, wb, oa, ra;
	wire [2:0] rcw, st;
	wire [1:0] ba;
	wire [3:0] ob;
	int n_mismatch = 0;
	int compares = 0;
	dcksl_ctl_model dcksl_ctl_model_inst (.core_clk_in, .cke_out(cke),
		.cs_n_out(cs_n), .rcw_n_out(rcw), .a10_out(a10), .ba_out(ba));
	dcksl_state dcksl_state_inst (.core_clk_in, .rst_n_in, .cke_in(cke),
		.cs_n_in(cs_n), .ras_n_in(rcw[2]), .cas_n_in(rcw[1]), .we_n_in(rcw[0]),
		.a10_in(a10), .ba_in(ba), .odt_in(odt), .dm_in(dm), .state_out(st),
		.illegal_out(ill), .write_beat_out(wb), .odt_active_out(oa),
		.read_allowed_out(ra), .open_banks_out(ob));
	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end
	task automatic check(input string what, input logic [3:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// CKE keeps its current level, no calibration mode
	task automatic tick(input int n);
		repeat (n) dcksl_ctl_model_inst.send(`DCKSL_CMD_DSL, cke, 2'h0, 1'b0);
	endtask
	task automatic step(input logic [2:0] c, input logic k,
		input logic [1:0] b, input logic al);
		dcksl_ctl_model_inst.send(c, k, b, al);
		// Outputs answer three edges after the pins, the write beat four; illegal pulses one cycle
		tick(3);
	endtask
	task automatic idle_cmds();
		for (int c = 3; c < 8; c++) begin
			step(c[2:0], 1'b1, 2'h0, 1'b0);
			check("idle illegal", ill, c == 4 || c == 5);
			check("idle state", st, `DCKSL_ST_IDLE);
		end
	endtask
	task automatic active_cmds();
		logic [2:0] bad[3] = '{`DCKSL_CMD_ACT, `DCKSL_CMD_REF, `DCKSL_CMD_MRS};
		step(`DCKSL_CMD_ACT, 1'b1, 2'h1, 1'b0);
		check("open rows", ob, 4'h2);
		foreach (bad[i]) begin
			step(bad[i], 1'b1, 2'h1, 1'b0);
			check("active illegal", ill, 1'b1);
			check("active state", st, `DCKSL_ST_ACTIVE);
		end
		step(`DCKSL_CMD_RD, 1'b1, 2'h1, 1'b0);
		check("read", st, `DCKSL_ST_READ);
		tick(2);
		check("read end", st, `DCKSL_ST_ACTIVE);
		for (int d = 0; d < 2; d++) begin
			dm = d[0];
			step(`DCKSL_CMD_WR, 1'b1, 2'h1, 1'b0);
			check("write", st, `DCKSL_ST_WRITE);
			tick(1);
			check("write beat", wb, !d[0]);
			tick(2);
		end
	endtask
	task automatic power_down();
		// only no-operation or deselect with the enable edge
		step(`DCKSL_CMD_NOP, 1'b0, 2'h0, 1'b0);
		check("active pd", st, `DCKSL_ST_APD);
		step(`DCKSL_CMD_DSL, 1'b1, 2'h0, 1'b0);
		check("active pd exit", st, `DCKSL_ST_ACTIVE);
		step(`DCKSL_CMD_PRE, 1'b1, 2'h0, 1'b1);
		check("rows closed", ob, 4'h0);
		step(`DCKSL_CMD_NOP, 1'b0, 2'h0, 1'b0);
		tick(3);
		check("precharge pd", st, `DCKSL_ST_PPD);
		step(`DCKSL_CMD_DSL, 1'b1, 2'h0, 1'b0);
		check("precharge pd exit", st, `DCKSL_ST_IDLE);
	endtask
	task automatic self_refresh();
		odt = 1'b1;
		step(`DCKSL_CMD_REF, 1'b0, 2'h0, 1'b0);
		check("self refresh", st, `DCKSL_ST_SREF);
		check("odt off", oa, 1'b0);
		step(`DCKSL_CMD_NOP, 1'b1, 2'h0, 1'b0);
		check("self refresh exit", st, `DCKSL_ST_IDLE);
		check("read held off", ra, 1'b0);
		tick(205);
		check("read allowed", ra, 1'b1);
		check("odt on", oa, 1'b1);
	endtask
	task automatic conclude();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		rst_n_in = 1'b0;
		odt = 1'b0;
		dm = 1'b0;
		repeat (4) @(posedge core_clk_in);
		#1 rst_n_in = 1'b1;
		tick(3);
		idle_cmds();
		active_cmds();
		power_down();
		self_refresh();
		conclude();
	end
endmodule // dcksl_state_test
`default_nettype wire
